// [hw/frame_pkg.sv]
// Constants shared by the API frame builder.
`default_nettype none
package frame_pkg;
  localparam logic [7:0] START_DELIM  = 8'h7E;
  localparam logic [7:0] TYPE_IO16    = 8'h83;
  localparam logic [7:0] TYPE_RESP    = 8'h88;
  localparam logic [7:0] TYPE_REQ     = 8'h08;
  localparam logic [7:0] TYPE_QREQ    = 8'h09;
  localparam logic [7:0] FMT_LEGACY   = 8'h02;
  localparam logic [15:0] ADDR_NONE   = 16'hFFFE;
  localparam logic [7:0] CKSUM_BASE   = 8'hFF;
  localparam logic [7:0] OPT_RSVD     = 8'h01;
  localparam logic [7:0] OPT_BCAST    = 8'h02;
  localparam logic [7:0] OPT_ALLPAN   = 8'h04;
  localparam logic [7:0] ST_OK        = 8'h00;
  localparam logic [7:0] ST_ERROR     = 8'h01;
  localparam logic [7:0] ST_BAD_CMD   = 8'h02;
  localparam logic [7:0] ST_BAD_PARM  = 8'h03;
  localparam logic [4:0] OFS_START    = 5'h00;
  localparam logic [4:0] OFS_LEN      = 5'h01;
  localparam logic [4:0] OFS_TYPE     = 5'h03;
  localparam logic [4:0] OFS_ADDR     = 5'h04;
  localparam logic [4:0] OFS_RSSI     = 5'h06;
  localparam logic [4:0] OFS_OPT      = 5'h07;
  localparam logic [4:0] OFS_NSAMP    = 5'h08;
  localparam logic [4:0] OFS_MASK     = 5'h09;
  localparam logic [4:0] OFS_DIG      = 5'h0B;
  localparam logic [4:0] OFS_ID       = 5'h04;
  localparam logic [4:0] OFS_CODE     = 5'h05;
  localparam logic [4:0] OFS_STATUS   = 5'h07;
  localparam logic [4:0] OFS_CDATA    = 5'h08;
  localparam int         FRAME_MAX    = 21;
  localparam int         DIG_BITS     = 9;
  localparam int         ANA_FIRST    = 9;
  localparam int         ANA_CH       = 4;
  localparam int         FIFO_DEPTH   = 4;
  localparam int         FIFO_WIDTH   = 9;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SEND = 3'b010,
    ST_CSUM = 3'b100
  } fr_state_e;
endpackage
`default_nettype wire

// [hw/api_framer.sv]
// API frame builder for sample indications and command responses, with its output FIFO.
// Contract
// - Every frame starts with one start delimiter byte at offset 0.
// - Sixteen-bit length at offset 1 counts bytes between length and checksum.
// - Short-address sample indication carries type code 0x83 at offset 3.
// - Sender network address occupies offsets 4 and 5.
// - Signal strength magnitude in dBm sits unsigned at offset 6.
// - Options byte at offset 7, bit 0 reserved, broadcast flags combinable.
// - Sample set count byte sits at offset 8.
// - Channel mask at offset 9: digital bits 0-8, analog bits 9-12.
// - Digital word at offset 11 only when digital mask bits are nonzero.
// - Digital word uses mask bit positions; disabled lines read zero.
// - One word per enabled analog channel, ascending order, after digital word.
// - Checksum is 0xFF minus low byte of sum from offset 3 on.
// - Sample frame only with legacy format 2 and remote address 0xFFFE; the code instead checks the own short address setting for 0xFFFE.
// - Sample frames go out only while the device runs in API mode.
// - Command requests 0x08 or 0x09 are answered with response type 0x88.
// - Several responses may carry the same frame identifier; host accepts them.
// - No response at all when the request frame identifier is zero.
// - Response holds identifier at 4, command code at 5, status at 7.
// - Command data at 8 only for queries; omitted when a parameter was set.
`timescale 1ns/1ps
`default_nettype none

module byte_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 4
) (
  input  wire logic             sys_clk_i,
  input  wire logic             rst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);
  localparam logic [PW:0]   FULL_CNT = (PW + 1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wp;
    logic [PW-1:0]               rp;
    logic [PW:0]                 cnt;
  } fifo_s;

  fifo_s q;
  fifo_s d;
  logic  push;
  logic  pop;

  function automatic logic [PW-1:0] step(input logic [PW-1:0] p);
    step = (p == LAST_PTR) ? '0 : PW'(p + 1'b1);
  endfunction

  assign in_ready_o  = (q.cnt != FULL_CNT);
  assign out_valid_o = (q.cnt != '0);
  assign out_data_o  = q.mem[q.rp];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wp] = in_data_i;
      d.wp        = step(q.wp);
    end
    if (pop) begin
      d.rp = step(q.rp);
    end
    case ({push, pop})
      2'b10:   d.cnt = (PW + 1)'(q.cnt + 1'b1);
      2'b01:   d.cnt = (PW + 1)'(q.cnt - 1'b1);
      default: d.cnt = q.cnt;
    endcase
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  a_fifo_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_data_o))
    else $error("FIFO output changed while stalled.");
  c_fifo_full: cover property (@(posedge sys_clk_i) disable iff (rst_i)
    !in_ready_o);
endmodule // byte_fifo

module api_framer (
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  input  wire logic        api_mode_i,
  input  wire logic [7:0]  api_output_format_select_i,
  input  wire logic        smp_valid_i,
  output logic             smp_ready_o,
  input  wire logic [15:0] own_short_address_setting_i,
  input  wire logic [15:0] smp_src_addr_i,
  input  wire logic [7:0]  smp_rssi_i,
  input  wire logic [7:0]  smp_options_i,
  input  wire logic [7:0]  smp_count_i,
  input  wire logic [15:0] smp_mask_i,
  input  wire logic [15:0] smp_digital_i,
  input  wire logic [15:0] analog_channel_0_i,
  input  wire logic [15:0] analog_channel_1_i,
  input  wire logic [15:0] analog_channel_2_i,
  input  wire logic [15:0] analog_channel_3_i,
  input  wire logic        cmd_valid_i,
  output logic             cmd_ready_o,
  input  wire logic [7:0]  cmd_req_type_i,
  input  wire logic [7:0]  cmd_frame_id_i,
  input  wire logic [15:0] cmd_code_i,
  input  wire logic [7:0]  cmd_status_i,
  input  wire logic        cmd_query_i,
  input  wire logic [15:0] cmd_data_i,
  output logic             out_valid_o,
  input  wire logic        out_ready_i,
  output logic [7:0]       out_data_o,
  output logic             out_last_o,
  output logic             smp_drop_o,
  output logic             cmd_drop_o
);
  typedef struct packed {
    frame_pkg::fr_state_e              state;
    logic [frame_pkg::FRAME_MAX-1:0][7:0] frame;
    logic [4:0]                        idx;
    logic [4:0]                        last;
    logic [7:0]                        sum;
    logic                              smp_drop;
    logic                              cmd_drop;
  } framer_s;

  framer_s     q;
  framer_s     d;
  logic [3:0][15:0] ana;
  logic        push_valid;
  logic        push_ready;
  logic [7:0]  push_data;
  logic        push_last;
  logic        smp_ok;
  logic        cmd_ok;
  logic        smp_take;
  logic        cmd_take;

  // Field bytes leave high byte first.
  function automatic logic [7:0] hi(input logic [15:0] w);
    hi = w[15:8];
  endfunction

  function automatic logic [7:0] lo(input logic [15:0] w);
    lo = w[7:0];
  endfunction

  function automatic logic [7:0] len_of(input logic [4:0] last);
    len_of = {3'h0, 5'(last - frame_pkg::OFS_TYPE + 5'h01)};
  endfunction

  assign ana = {analog_channel_3_i, analog_channel_2_i,
                analog_channel_1_i, analog_channel_0_i};

  assign smp_ok = api_mode_i
                & (api_output_format_select_i == frame_pkg::FMT_LEGACY)
                & (own_short_address_setting_i == frame_pkg::ADDR_NONE);
  assign cmd_ok = ((cmd_req_type_i == frame_pkg::TYPE_REQ)
                 | (cmd_req_type_i == frame_pkg::TYPE_QREQ))
                & (cmd_frame_id_i != 8'h00);

  // Commands win over samples so a host waiting for an answer is not starved.
  assign cmd_ready_o = (q.state == frame_pkg::ST_IDLE);
  assign smp_ready_o = (q.state == frame_pkg::ST_IDLE) & ~cmd_valid_i;
  assign cmd_take    = cmd_valid_i & cmd_ready_o;
  assign smp_take    = smp_valid_i & smp_ready_o;
  assign smp_drop_o  = q.smp_drop;
  assign cmd_drop_o  = q.cmd_drop;

  always_comb begin
    logic [4:0] p;
    p          = frame_pkg::OFS_DIG;
    d          = q;
    d.smp_drop = 1'b0;
    d.cmd_drop = 1'b0;
    push_valid = 1'b0;
    push_data  = 8'h00;
    push_last  = 1'b0;
    case (q.state)
      frame_pkg::ST_IDLE: begin
        d.idx = frame_pkg::OFS_START;
        d.sum = 8'h00;
        if (cmd_take) begin
          if (cmd_ok) begin
            d.frame = '0;
            d.frame[frame_pkg::OFS_START] = frame_pkg::START_DELIM;
            d.frame[frame_pkg::OFS_TYPE] = frame_pkg::TYPE_RESP;
            d.frame[frame_pkg::OFS_ID]             = cmd_frame_id_i;
            d.frame[frame_pkg::OFS_CODE]           = hi(cmd_code_i);
            d.frame[frame_pkg::OFS_CODE + 5'h01]   = lo(cmd_code_i);
            d.frame[frame_pkg::OFS_STATUS]         = cmd_status_i;
            p = frame_pkg::OFS_CDATA;
            if (cmd_query_i) begin
              d.frame[p]         = hi(cmd_data_i);
              d.frame[p + 5'h01] = lo(cmd_data_i);
              p = 5'(p + 5'h02);
            end
            d.last = 5'(p - 5'h01);
            d.frame[frame_pkg::OFS_LEN + 5'h01] = len_of(d.last);
            d.state = frame_pkg::ST_SEND;
          end else begin
            d.cmd_drop = 1'b1;
          end
        end else if (smp_take) begin
          if (smp_ok) begin
            d.frame = '0;
            d.frame[frame_pkg::OFS_START] = frame_pkg::START_DELIM;
            d.frame[frame_pkg::OFS_TYPE] = frame_pkg::TYPE_IO16;
            d.frame[frame_pkg::OFS_ADDR]         = hi(smp_src_addr_i);
            d.frame[frame_pkg::OFS_ADDR + 5'h01] = lo(smp_src_addr_i);
            d.frame[frame_pkg::OFS_RSSI] = smp_rssi_i;
            d.frame[frame_pkg::OFS_OPT] = smp_options_i & ~frame_pkg::OPT_RSVD;
            d.frame[frame_pkg::OFS_NSAMP] = smp_count_i;
            d.frame[frame_pkg::OFS_MASK]         = hi(smp_mask_i);
            d.frame[frame_pkg::OFS_MASK + 5'h01] = lo(smp_mask_i);
            if (|smp_mask_i[frame_pkg::DIG_BITS-1:0]) begin
              d.frame[p] = {7'h00, smp_digital_i[8] & smp_mask_i[8]};
              d.frame[p + 5'h01] = smp_digital_i[7:0] & smp_mask_i[7:0];
              p = 5'(p + 5'h02);
            end
            for (int ch = 0; ch < frame_pkg::ANA_CH; ch++) begin
              if (smp_mask_i[frame_pkg::ANA_FIRST + ch]) begin
                d.frame[p]         = hi(ana[ch]);
                d.frame[p + 5'h01] = lo(ana[ch]);
                p = 5'(p + 5'h02);
              end
            end
            d.last = 5'(p - 5'h01);
            d.frame[frame_pkg::OFS_LEN + 5'h01] = len_of(d.last);
            d.state = frame_pkg::ST_SEND;
          end else begin
            d.smp_drop = 1'b1;
          end
        end
      end
      frame_pkg::ST_SEND: begin
        push_valid = 1'b1;
        push_data  = q.frame[q.idx];
        if (push_ready) begin
          if (q.idx >= frame_pkg::OFS_TYPE) begin
            d.sum = 8'(q.sum + push_data);
          end
          if (q.idx == q.last) begin
            d.state = frame_pkg::ST_CSUM;
          end else begin
            d.idx = 5'(q.idx + 5'h01);
          end
        end
      end
      frame_pkg::ST_CSUM: begin
        push_valid = 1'b1;
        push_data  = 8'(frame_pkg::CKSUM_BASE - q.sum);
        push_last  = 1'b1;
        if (push_ready) begin
          d.state = frame_pkg::ST_IDLE;
        end
      end
      default: begin
        d.state = frame_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      q       <= '0;
      q.state <= frame_pkg::ST_IDLE;
    end else begin
      q <= d;
    end
  end

  // The FIFO decouples the byte sequencer from a host that stalls mid-frame.
  byte_fifo #(
    .WIDTH (frame_pkg::FIFO_WIDTH),
    .DEPTH (frame_pkg::FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_i   (sys_clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (push_valid),
    .in_ready_o  (push_ready),
    .in_data_i   ({push_last, push_data}),
    .out_valid_o (out_valid_o),
    .out_ready_i (out_ready_i),
    .out_data_o  ({out_last_o, out_data_o})
  );

  wire send_st = (q.state == frame_pkg::ST_SEND);
  a_start_byte: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    send_st && q.idx == frame_pkg::OFS_START |-> push_data == frame_pkg::START_DELIM)
    else $error("First frame byte is not the start delimiter.");
  // Length counts offset 3 through the last payload byte, so it is last minus two.
  a_len_field: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    send_st && q.idx == frame_pkg::OFS_LEN + 5'h01
    |-> push_data == {3'h0, q.last} - {3'h0, frame_pkg::OFS_LEN} - 8'h01)
    else $error("Length byte does not match the payload size.");
  a_type_code: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    smp_take && !cmd_take && smp_ok |=> q.frame[frame_pkg::OFS_TYPE] == frame_pkg::TYPE_IO16)
    else $error("Sample frame lacks its type code.");
  a_resp_type: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    cmd_take && cmd_ok |=> q.frame[frame_pkg::OFS_TYPE] == frame_pkg::TYPE_RESP
      && q.frame[frame_pkg::OFS_ID] == $past(cmd_frame_id_i))
    else $error("Response type or identifier wrong.");
  a_dig_word: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    smp_take && smp_ok && |smp_mask_i[8:0]
    |=> {q.frame[frame_pkg::OFS_DIG], q.frame[frame_pkg::OFS_DIG + 5'h01]}
        == ($past(smp_digital_i) & $past(smp_mask_i) & 16'h01FF))
    else $error("Digital word not masked.");
  a_sample_end: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    smp_take && smp_ok |=> q.last == 5'(5'd10
      + ((|($past(smp_mask_i) & 16'h01FF)) ? 5'd2 : 5'd0)
      + 5'(2 * $countones($past(smp_mask_i) & 16'h1E00))))
    else $error("Sample frame size wrong.");
  a_drop_gate: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    smp_take && !smp_ok |=> q.state == frame_pkg::ST_IDLE && smp_drop_o)
    else $error("Sample framed outside API legacy mode.");
  a_zero_id: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    cmd_take && cmd_frame_id_i == 8'h00 |=> q.state == frame_pkg::ST_IDLE && cmd_drop_o)
    else $error("Response produced for identifier zero.");
  a_cmd_size: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    cmd_take && cmd_ok |=> q.last == ($past(cmd_query_i) ? 5'd9 : 5'd7))
    else $error("Command data presence wrong.");
  a_csum_last: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    send_st && q.idx == q.last && push_ready
    |=> q.state == frame_pkg::ST_CSUM && push_last
        && push_data == 8'(frame_pkg::CKSUM_BASE - q.sum))
    else $error("Checksum byte not sent after payload.");
  c_sample_frame: cover property (@(posedge sys_clk_i) disable iff (rst_i)
    smp_take && smp_ok && smp_mask_i[12]);
  c_query_resp: cover property (@(posedge sys_clk_i) disable iff (rst_i)
    cmd_take && cmd_ok && cmd_query_i);
  c_sample_drop: cover property (@(posedge sys_clk_i) disable iff (rst_i)
    smp_take && !smp_ok);
  c_stall_mid: cover property (@(posedge sys_clk_i) disable iff (rst_i)
    send_st && !push_ready);
endmodule // api_framer
`default_nettype wire

// [verification/host_reader.sv]
// Host-side reader model that collects API frame bytes from the framer output.
`timescale 1ns/1ps
`default_nettype none
module host_reader (
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  input  wire logic       slow_i,
  input  wire logic       out_valid_i,
  input  wire logic [7:0] out_data_i,
  input  wire logic       out_last_i,
  output logic            out_ready_o
);
  logic [7:0] rx_q [$];
  int         frames = 0;
  int         last_at = 0;

  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      out_ready_o <= 1'b0;
    end else begin
      // A slow host stalls every other cycle so the FIFO fills and backs up.
      out_ready_o <= slow_i ? ~out_ready_o : 1'b1;
      if (out_valid_i === 1'b1 && out_ready_o) begin
        rx_q.push_back(out_data_i);
        if (out_last_i === 1'b1) begin
          frames = frames + 1;
          last_at = rx_q.size();
        end
      end
    end
  end
endmodule // host_reader
`default_nettype wire

// [verification/testbench.sv]
// Self-checking bench for the API frame builder.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        sys_clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        api_mode_i = 1'b1;
  logic [7:0]  api_output_format_select_i = 8'h02;
  logic [15:0] own_short_address_setting_i = 16'hFFFE;
  logic        smp_valid_i = 1'b0;
  logic [15:0] smp_src_addr_i = 16'hA1B2;
  logic [7:0]  smp_rssi_i = 8'h28;
  logic [7:0]  smp_options_i = 8'h00;
  logic [7:0]  smp_count_i = 8'h01;
  logic [15:0] smp_mask_i = 16'h0000;
  logic [15:0] smp_digital_i = 16'h0000;
  logic [15:0] ana [4] = '{16'h0A01, 16'h1B02, 16'h2C03, 16'h3D04};
  logic        cmd_valid_i = 1'b0;
  logic [7:0]  cmd_req_type_i = 8'h00;
  logic [7:0]  cmd_frame_id_i = 8'h00;
  logic [15:0] cmd_code_i = 16'h0000;
  logic [7:0]  cmd_status_i = 8'h00;
  logic        cmd_query_i = 1'b0;
  logic [15:0] cmd_data_i = 16'h0000;
  logic        slow = 1'b0;
  logic        smp_ready_o, cmd_ready_o, out_valid_o, out_ready_i, out_last_o;
  logic        smp_drop_o, cmd_drop_o;
  logic [7:0]  out_data_o;
  logic [7:0]  pay_q [$];
  logic [7:0]  exp_q [$];
  int          fail_count = 0;
  int          comparisons = 0;
  int          cycles = 0;

  api_framer dut (.sys_clk_i, .rst_i, .api_mode_i, .api_output_format_select_i,
    .smp_valid_i, .smp_ready_o, .own_short_address_setting_i, .smp_src_addr_i,
    .smp_rssi_i, .smp_options_i, .smp_count_i, .smp_mask_i, .smp_digital_i,
    .analog_channel_0_i(ana[0]), .analog_channel_1_i(ana[1]),
    .analog_channel_2_i(ana[2]), .analog_channel_3_i(ana[3]), .cmd_valid_i,
    .cmd_ready_o, .cmd_req_type_i, .cmd_frame_id_i, .cmd_code_i, .cmd_status_i,
    .cmd_query_i, .cmd_data_i, .out_valid_o, .out_ready_i, .out_data_o, .out_last_o,
    .smp_drop_o, .cmd_drop_o);

  host_reader host (.sys_clk_i, .rst_i, .slow_i(slow), .out_valid_i(out_valid_o),
    .out_data_i(out_data_o), .out_last_i(out_last_o), .out_ready_o(out_ready_i));

  always #12.5 sys_clk_i = ~sys_clk_i;

  task automatic print_verdict();
    $display("Counts: comparisons=%0d mismatches=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      print_verdict();
    end
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  // Turns the queued payload into a whole expected frame with length and checksum.
  task automatic wrap();
    logic [7:0] sum;
    sum = 8'h00;
    foreach (pay_q[i]) sum += pay_q[i];
    exp_q.push_back(frame_pkg::START_DELIM);
    exp_q.push_back(8'h00);
    exp_q.push_back(8'(pay_q.size()));
    foreach (pay_q[i]) exp_q.push_back(pay_q[i]);
    exp_q.push_back(frame_pkg::CKSUM_BASE - sum);
    pay_q.delete();
  endtask

  task automatic expect_frames(input int n);
    for (int k = 0; k < 400 && host.frames < n; k++) @(posedge sys_clk_i);
    #1;
    check(16'(host.frames), 16'(n));
    check(16'(host.rx_q.size()), 16'(exp_q.size()));
    check(16'(host.last_at), 16'(exp_q.size()));
    foreach (exp_q[i]) if (i < host.rx_q.size()) check(host.rx_q[i], exp_q[i]);
    host.rx_q.delete();
    host.frames = 0;
    exp_q.delete();
  endtask

  task automatic take(ref logic valid, ref logic ready);
    // One edge passes first so a back-to-back request never lowers and raises valid at once.
    @(posedge sys_clk_i);
    #1;
    valid = 1'b1;
    for (int k = 0; k < 400 && ready !== 1'b1; k++) begin
      @(posedge sys_clk_i);
      #1;
    end
    @(posedge sys_clk_i);
    #1;
    valid = 1'b0;
  endtask

  task automatic send_cmd(input logic [7:0] t, id, input logic [15:0] code,
                          input logic [7:0] st, input logic q, input logic [15:0] d);
    cmd_req_type_i = t;
    cmd_frame_id_i = id;
    cmd_code_i = code;
    cmd_status_i = st;
    cmd_query_i = q;
    cmd_data_i = d;
    take(cmd_valid_i, cmd_ready_o);
    if (id != 8'h00 && (t == frame_pkg::TYPE_REQ || t == frame_pkg::TYPE_QREQ)) begin
      pay_q = {frame_pkg::TYPE_RESP, id, code[15:8], code[7:0], st};
      if (q) pay_q = {pay_q, d[15:8], d[7:0]};
      wrap();
    end
  endtask

  task automatic send_smp(input logic [15:0] m, input logic [15:0] dig, input logic [7:0] opt);
    logic [15:0] dm;
    smp_mask_i = m;
    smp_digital_i = dig;
    smp_options_i = opt;
    take(smp_valid_i, smp_ready_o);
    pay_q = {frame_pkg::TYPE_IO16, 8'hA1, 8'hB2, 8'h28, opt & 8'hFE, 8'h01, m[15:8], m[7:0]};
    dm = dig & {7'h00, m[8:0]};
    if (m[8:0] != 9'h000) pay_q = {pay_q, dm[15:8], dm[7:0]};
    for (int c = 0; c < 4; c++) if (m[9+c]) pay_q = {pay_q, ana[c][15:8], ana[c][7:0]};
    wrap();
  endtask

  task automatic expect_drop(ref logic drop);
    int pulses;
    pulses = 0;
    for (int k = 0; k < 6; k++) begin
      if (drop === 1'b1) pulses++;
      @(posedge sys_clk_i);
      #1;
    end
    check(16'(pulses), 16'h0001);
    repeat (30) @(posedge sys_clk_i);
    #1;
    check(16'(host.frames), 16'h0000);
    exp_q.delete();
  endtask

  task automatic test_cmd_query();
    send_cmd(8'h08, 8'h17, 16'h5450, frame_pkg::ST_OK, 1'b1, 16'hFFFE);
    expect_frames(1);
    $display("test cmd_query done");
  endtask

  task automatic test_cmd_set_statuses();
    logic [7:0] st [4] = '{frame_pkg::ST_OK, frame_pkg::ST_ERROR,
                           frame_pkg::ST_BAD_CMD, frame_pkg::ST_BAD_PARM};
    // Back-to-back responses sharing one identifier.
    foreach (st[i]) send_cmd(frame_pkg::TYPE_QREQ, 8'h01, 16'h4E49, st[i], 1'b0, 16'h1234);
    expect_frames(4);
    $display("test cmd_set_statuses done");
  endtask

  task automatic test_cmd_drops();
    send_cmd(frame_pkg::TYPE_REQ, 8'h00, 16'h4E49, 8'h00, 1'b1, 16'h0001);
    expect_drop(cmd_drop_o);
    send_cmd(8'h10, 8'h05, 16'h4E49, 8'h00, 1'b1, 16'h0001);
    expect_drop(cmd_drop_o);
    $display("test cmd_drops done");
  endtask

  task automatic test_samples();
    slow = 1'b1;
    send_smp(16'h1FFF, 16'hFFFF, 8'h07);
    expect_frames(1);
    slow = 1'b0;
    send_smp(16'h1400, 16'hFFFF, 8'h02);
    send_smp(16'h0105, 16'hFEFF, 8'h04);
    expect_frames(2);
    $display("test samples done");
  endtask

  task automatic test_sample_gating();
    logic [24:0] cfg [3] = '{{1'b0, 8'h02, 16'hFFFE}, {1'b1, 8'h01, 16'hFFFE},
                             {1'b1, 8'h02, 16'h1234}};
    foreach (cfg[i]) begin
      {api_mode_i, api_output_format_select_i, own_short_address_setting_i} = cfg[i];
      send_smp(16'h0201, 16'h0001, 8'h00);
      expect_drop(smp_drop_o);
    end
    {api_mode_i, api_output_format_select_i, own_short_address_setting_i} = {1'b1, 8'h02, 16'hFFFE};
    $display("test sample_gating done");
  endtask

  initial begin
    repeat (4) @(posedge sys_clk_i);
    #1;
    rst_i = 1'b0;
    test_cmd_query();
    test_cmd_set_statuses();
    test_cmd_drops();
    test_samples();
    test_sample_gating();
    print_verdict();
  end
endmodule // testbench
`default_nettype wire
